/* core/uhp_port_ctrl.sv */
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Functional notes
// - Overcurrent-active reads 0 while the overcurrent pin is high.
// - During port reset the port is disabled and drives reset (SE0).
// - Low-speed bit reads 1 for low-speed device, 0 full speed; read only.
// - Bit 7 of the port register always reads 1.
// - Software writing 1 to resume_detect drives K onto the bus.
// - While suspended, a J-to-K lasting 32 us sets resume_detect.
// - Detected K is echoed while resume_detect is 1 and port suspended.
// - Clearing resume_detect sends a low-speed EOP; bit stays 1 until done.
// - Line-state shows D+ in bit 4 and D- in bit 5.
// - Line-state is sampled only at the EOF2 point.
// - Enable-change sets only on hardware disable by disconnect or EOF2 fault.
// - Enable-change clears by writing 1; writing 0 keeps it.
// - Suspend means suspend and enable both 1; only reset and resume signalling (K, closing EOP) pass downstream.
// - Overcurrent-active reads 1 while the overcurrent pin is low.
// - Only software enables the port; hardware or software may disable.
module uhp_port_ctrl
    import uhp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input uhp_line_s line_in,
    input wire logic oc_n,
    input wire logic dev_connected,
    input wire logic port_reset_req,
    input wire logic port_fault,
    input wire logic eof2,
    output uhp_line_s line_out,
    output logic line_oe_n,
    output logic irq
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic conn;
        logic conn_chg;
        logic en;
        logic susp;
        logic en_chg;
        logic rsm;
        logic rsm_hw;
        logic rsm_end;
        logic eop_req;
        logic [1:0] line_st;
        logic ls;
        logic prst;
        logic oc_act;
        logic oc_prev;
        logic oc_ind;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imask;
    } uhp_pc_s;

    uhp_pc_s r;
    uhp_pc_s n;
    logic k_det;
    logic eop_busy;
    logic eop_done;
    logic suspended;
    logic drive_k;
    logic wr_acc;
    logic hw_dis;
    logic conn_evt;
    logic oc_rise;
    logic [IRQ_W-1:0] ev;
    logic [31:0] port_now;

    // Assemble the port word from current state
    function automatic logic [31:0] port_word(input uhp_pc_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[B_CONN] = s.conn;
        w[B_CONN_CHG] = s.conn_chg;
        w[B_EN] = s.en;
        w[B_EN_CHG] = s.en_chg;
        w[B_LINE_DM:B_LINE_DP] = s.line_st;
        w[B_RSM] = s.rsm;
        w[B_RSVD1] = RSVD1_VAL;
        w[B_LS] = s.ls;
        w[B_PRST] = s.prst;
        w[B_OC_ACT] = s.oc_act;
        w[B_OC_IND] = s.oc_ind;
        w[B_SUSP] = s.susp;
        return w;
    endfunction

    // Suspend is the pair suspend and enable both set
    assign suspended = r.susp && r.en;
    // Word as software would read it now; the overcurrent checks look at the visible bit, p_oc_clear at the raw flop as well
    assign port_now = port_word(r);
    assign wr_acc = psel && penable && pwrite && r.pready;
    assign hw_dis = r.en && ((r.conn && !dev_connected) || (eof2 && port_fault));
    assign conn_evt = r.conn ^ dev_connected;
    assign oc_rise = r.oc_act && !r.oc_prev;
    // Hardware-set resume only echoes while still suspended
    assign drive_k = r.rsm && !r.rsm_end && !r.prst && (!r.rsm_hw || suspended);

    // Event vector in interrupt layout
    always_comb
    begin
        ev = '0;
        ev[I_EN_CHG] = hw_dis;
        ev[I_RSM] = k_det;
        ev[I_OC] = oc_rise;
        ev[I_CONN] = conn_evt;
    end

    uhp_k_detect u_kdet (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .armed(suspended && !r.rsm),
        .ls(r.ls),
        .line_in(line_in),
        .detect(k_det)
    );

    uhp_line_drv u_drv (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ls(r.ls),
        .drive_reset(r.prst),
        .drive_k(drive_k),
        .start_eop(r.eop_req),
        .line_out(line_out),
        .line_oe_n(line_oe_n),
        .eop_busy(eop_busy),
        .eop_done(eop_done)
    );

    // Software writes first, then hardware events so hardware wins over a same-cycle write
    always_comb
    begin
        n = r;
        n.eop_req = 1'b0;
        n.prst = port_reset_req;
        n.oc_act = ~oc_n;
        n.oc_prev = r.oc_act;
        n.conn = dev_connected;
        if (eof2)
            n.line_st = {line_in.dm, line_in.dp};
        // Speed is judged from the idle level only while not enabled
        if (eof2 && !r.en && dev_connected)
            n.ls = line_in.dm && !line_in.dp;

        if (wr_acc && paddr == OFF_PORT)
        begin
            n.en = pwdata[B_EN];
            n.susp = pwdata[B_SUSP];
            if (pwdata[B_CONN_CHG])
                n.conn_chg = 1'b0;
            if (pwdata[B_EN_CHG])
                n.en_chg = 1'b0;
            if (pwdata[B_OC_IND])
                n.oc_ind = 1'b0;
            if (pwdata[B_RSM] && !r.rsm)
            begin
                n.rsm = 1'b1;
                n.rsm_hw = 1'b0;
            end
            else if (!pwdata[B_RSM] && r.rsm && !r.rsm_end)
            begin
                n.rsm_end = 1'b1;
                n.eop_req = 1'b1;
            end
        end
        if (wr_acc && paddr == OFF_ISTAT)
            n.ist = r.ist & ~pwdata[IRQ_W-1:0];
        if (wr_acc && paddr == OFF_IMASK)
            n.imask = pwdata[IRQ_W-1:0];

        // Hardware may only take the port down
        if (r.prst || hw_dis)
        begin
            n.en = 1'b0;
            n.susp = 1'b0;
        end
        if (hw_dis)
            n.en_chg = 1'b1;
        if (conn_evt)
            n.conn_chg = 1'b1;
        if (oc_rise)
            n.oc_ind = 1'b1;
        if (k_det)
        begin
            n.rsm = 1'b1;
            n.rsm_hw = 1'b1;
        end
        // The bit drops only when the EOP has left the wire
        if (eop_done && r.rsm_end)
        begin
            n.rsm = 1'b0;
            n.rsm_end = 1'b0;
            n.rsm_hw = 1'b0;
        end
        n.ist = n.ist | ev;
        n.irq = |(n.ist & n.imask);

        // APB: one wait state, answer registered so outputs come from flops
        if (psel && penable && !r.pready)
        begin
            n.pready = 1'b1;
            n.pslverr = !(paddr == OFF_PORT || paddr == OFF_ISTAT || paddr == OFF_IMASK);
            unique case (paddr)
                OFF_PORT: n.prdata = port_word(r);
                OFF_ISTAT: n.prdata = {28'h0000000, r.ist};
                OFF_IMASK: n.prdata = {28'h0000000, r.imask};
                default: n.prdata = 32'h0000_0000;
            endcase
        end
        else
        begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end
    end

    // Reset clears every flag; mask starts closed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.imask <= IMASK_RST;
        end
        else if (ce)
            r <= n;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign irq = r.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_oc_clear;
        (ce && oc_n) ##1 (ce && oc_n) |-> !r.oc_act && !port_now[B_OC_ACT];
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("Overcurrent active with pin high");

    property p_oc_set;
        (ce && !oc_n) ##1 ce |-> port_now[B_OC_ACT];
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("Overcurrent active missing with pin low");

    property p_prst_dis;
        (ce && r.prst) |=> !r.en;
    endproperty
    a_prst_dis: assert property (p_prst_dis) else $error("Port enabled during reset");

    property p_rsvd_read;
        (r.pready && psel && !pwrite && paddr == OFF_PORT) |-> r.prdata[B_RSVD1];
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("Reserved bit read as 0");

    property p_line_hold;
        (ce && !eof2) |=> $stable(r.line_st);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("Line state changed outside EOF2");

    property p_enchg_cause;
        (ce && !r.en_chg && !hw_dis) |=> !r.en_chg;
    endproperty
    a_enchg_cause: assert property (p_enchg_cause) else $error("Enable change set without disable");

    property p_enchg_w0;
        (ce && r.en_chg && wr_acc && paddr == OFF_PORT && !pwdata[B_EN_CHG]) |=> r.en_chg;
    endproperty
    a_enchg_w0: assert property (p_enchg_w0) else $error("Enable change lost on write of 0");

    property p_no_hw_en;
        (ce && !r.en && !(wr_acc && paddr == OFF_PORT && pwdata[B_EN])) |=> !r.en;
    endproperty
    a_no_hw_en: assert property (p_no_hw_en) else $error("Port enabled without software");

    property p_rsm_hold;
        (ce && r.rsm && r.rsm_end && !eop_done) |=> r.rsm;
    endproperty
    a_rsm_hold: assert property (p_rsm_hold) else $error("Resume bit dropped before EOP end");

    property p_echo_k;
        (ce && r.rsm && r.rsm_hw && suspended && !r.rsm_end && !r.prst) |=>
            (!line_oe_n && line_out == uhp_kstate(r.ls));
    endproperty
    a_echo_k: assert property (p_echo_k) else $error("Detected resume not echoed");

    c_hw_dis: cover property (ce && hw_dis);
    c_irq: cover property (r.irq);
endmodule

/* core/uhp_pkg.sv */
package uhp_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_PORT = 8'h00;
    localparam logic [7:0] OFF_ISTAT = 8'h04;
    localparam logic [7:0] OFF_IMASK = 8'h08;

    // Field positions of port_status_control
    localparam int B_CONN = 0;
    localparam int B_CONN_CHG = 1;
    localparam int B_EN = 2;
    localparam int B_EN_CHG = 3;
    localparam int B_LINE_DP = 4;
    localparam int B_LINE_DM = 5;
    localparam int B_RSM = 6;
    localparam int B_RSVD1 = 7;
    localparam int B_LS = 8;
    localparam int B_PRST = 9;
    localparam int B_OC_ACT = 10;
    localparam int B_OC_IND = 11;
    localparam int B_SUSP = 12;

    // Reserved bit 7 value
    localparam logic RSVD1_VAL = 1'b1;

    // Interrupt status/mask layout
    localparam int IRQ_W = 4;
    localparam int I_EN_CHG = 0;
    localparam int I_RSM = 1;
    localparam int I_OC = 2;
    localparam int I_CONN = 3;
    localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_MHZ = 25;
    localparam int K_DET_US = 32;
    localparam int K_DET_CYC = K_DET_US * CLK_MHZ;
    localparam int EOP_SE0_NS = 1334;
    localparam int EOP_J_NS = 667;
    localparam int EOP_SE0_CYC = (EOP_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOP_J_CYC = (EOP_J_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bus line pair
    typedef struct packed {
        logic dp;
        logic dm;
    } uhp_line_s;

    // Line driver states
    typedef enum logic [4:0] {
        LD_IDLE = 5'b00001,
        LD_RST = 5'b00010,
        LD_K = 5'b00100,
        LD_SE0 = 5'b01000,
        LD_J = 5'b10000
    } uhp_ld_state_e;

    // K state for the attached speed; J is its inverse
    function automatic uhp_line_s uhp_kstate(input logic ls);
        uhp_line_s k;
        k.dp = ls;
        k.dm = ~ls;
        return k;
    endfunction

endpackage

/* core/uhp_k_detect.sv */
`timescale 1ns/1ns
module uhp_k_detect
    import uhp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic armed,
    input wire logic ls,
    input uhp_line_s line_in,
    output logic detect
);
    typedef struct packed {
        logic last_j;
        logic run;
        logic [9:0] cnt;
        logic fired;
        logic det;
    } uhp_kd_s;

    uhp_kd_s r;
    uhp_kd_s n;
    logic is_k;
    logic is_j;

    // Count a K that directly followed a J; a glitch back restarts
    always_comb
    begin
        n = r;
        is_k = (line_in == uhp_kstate(ls));
        is_j = (line_in == ~uhp_kstate(ls));
        n.det = 1'b0;
        n.last_j = is_j;
        if (!armed || !is_k)
        begin
            n.run = 1'b0;
            n.cnt = '0;
            n.fired = 1'b0;
        end
        else if (r.run || r.last_j)
        begin
            n.run = 1'b1;
            if (!r.fired)
            begin
                n.cnt = r.cnt + 10'h001;
                if (r.cnt == 10'(K_DET_CYC - 1))
                begin
                    n.det = 1'b1;
                    n.fired = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else if (ce)
            r <= n;
    end

    assign detect = r.det;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_kdet_len;
        r.det |-> (r.cnt == 10'(K_DET_CYC)) && $past(armed);
    endproperty
    a_kdet_len: assert property (p_kdet_len) else $error("K detect without full persistence");

    property p_kdet_cov;
        r.det;
    endproperty
    c_kdet_cov: cover property (p_kdet_cov);
endmodule

/* core/uhp_line_drv.sv */
`timescale 1ns/1ns
module uhp_line_drv
    import uhp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic ls,
    input wire logic drive_reset,
    input wire logic drive_k,
    input wire logic start_eop,
    output uhp_line_s line_out,
    output logic line_oe_n,
    output logic eop_busy,
    output logic eop_done
);
    typedef struct packed {
        uhp_ld_state_e st;
        logic [5:0] cnt;
        uhp_line_s line;
        logic oe_n;
        logic busy;
        logic done;
    } uhp_ld_s;

    uhp_ld_s r;
    uhp_ld_s n;

    // Reset outranks everything; an EOP runs to its end once begun
    always_comb
    begin
        n = r;
        n.done = 1'b0;
        n.cnt = r.cnt + 6'h01;
        unique case (r.st)
            LD_IDLE, LD_K, LD_RST:
            begin
                n.cnt = '0;
                if (drive_reset)
                    n.st = LD_RST;
                else if (start_eop)
                    n.st = LD_SE0;
                else if (drive_k)
                    n.st = LD_K;
                else
                    n.st = LD_IDLE;
            end
            LD_SE0:
            begin
                if (drive_reset)
                    n.st = LD_RST;
                else if (r.cnt == 6'(EOP_SE0_CYC - 1))
                begin
                    n.st = LD_J;
                    n.cnt = '0;
                end
            end
            LD_J:
            begin
                if (drive_reset)
                    n.st = LD_RST;
                if (drive_reset || r.cnt == 6'(EOP_J_CYC - 1))
                begin
                    n.done = 1'b1;
                    n.cnt = '0;
                    if (!drive_reset)
                        n.st = LD_IDLE;
                end
            end
            default:
                n.st = LD_IDLE;
        endcase
        n.busy = (n.st == LD_SE0) || (n.st == LD_J);
        n.oe_n = (n.st == LD_IDLE);
        unique case (n.st)
            LD_K: n.line = uhp_kstate(ls);
            LD_J: n.line = ~uhp_kstate(ls);
            default: n.line = '0; // SE0 for reset and EOP
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '{st: LD_IDLE, cnt: 6'h00, line: 2'h0, oe_n: 1'b1, busy: 1'b0, done: 1'b0};
        else if (ce)
            r <= n;
    end

    assign line_out = r.line;
    assign line_oe_n = r.oe_n;
    assign eop_busy = r.busy;
    assign eop_done = r.done;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_se0;
        (ce && drive_reset) |=> (!r.oe_n && r.line == 2'h0);
    endproperty
    a_rst_se0: assert property (p_rst_se0) else $error("Reset not driven as SE0");

    property p_k_drive;
        (ce && drive_k && !drive_reset && !start_eop && r.st == LD_IDLE) |=> (!r.oe_n && r.line == uhp_kstate(ls));
    endproperty
    a_k_drive: assert property (p_k_drive) else $error("Resume K not driven");

    property p_eop_len;
        $rose(r.busy) |-> r.busy[*8];
    endproperty
    a_eop_len: assert property (p_eop_len) else $error("Low-speed EOP too short");

    property p_eop_cov;
        r.done;
    endproperty
    c_eop_cov: cover property (p_eop_cov);
endmodule

/* tb/uhp_dev_model.sv */
`timescale 1ns/1ns
// Attached function: idle J at its own speed, SE0 through pull-downs when unplugged
module uhp_dev_model
    import uhp_pkg::*;
(
    input wire logic pclk,
    input wire logic plugged,
    input wire logic ls,
    input wire logic send_k,
    input uhp_line_s host_line,
    input wire logic host_oe_n,
    output uhp_line_s line_in,
    output logic dev_connected
);
    uhp_line_s dev_line;

    // Device drives K only while asked, otherwise its idle J
    always_ff @(posedge pclk)
    begin
        if (!plugged)
            dev_line <= '0;
        else if (send_k)
            dev_line <= '{ls, ~ls};
        else
            dev_line <= '{~ls, ls};
    end

    // Host drive wins over the device, so the wire shows what the port sends
    assign line_in = host_oe_n ? dev_line : host_line;
    assign dev_connected = plugged;
endmodule

/* tb/uhp_port_ctrl_tb.sv */
`timescale 1ns/1ns
module uhp_port_ctrl_tb;
    import uhp_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic oc_n = 1'b1;
    logic port_reset_req = 1'b0;
    logic port_fault = 1'b0;
    logic eof2 = 1'b0;
    logic plugged = 1'b0;
    logic ls = 1'b0;
    logic send_k = 1'b0;
    logic dev_connected;
    logic line_oe_n;
    logic irq;
    uhp_line_s line_in;
    uhp_line_s line_out;
    int err_count = 0;
    int n_checks = 0;

    // Clock of 25 MHz
    always #20 pclk = ~pclk;

    uhp_port_ctrl DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .oc_n(oc_n), .dev_connected(dev_connected),
        .port_reset_req(port_reset_req), .port_fault(port_fault), .eof2(eof2),
        .line_out(line_out), .line_oe_n(line_oe_n), .irq(irq));

    uhp_dev_model PEER (.pclk(pclk), .plugged(plugged), .ls(ls), .send_k(send_k),
        .host_line(line_out), .host_oe_n(line_oe_n), .line_in(line_in), .dev_connected(dev_connected));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        // A slave that never answers counts against the run
        if (pready !== 1'b1)
            err_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let one edge pass so a following call never re-drives psel in this time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q & m, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic frame_end();
        eof2 <= 1'b1;
        @(posedge pclk);
        eof2 <= 1'b0;
        wait_cyc(2);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rchk(OFF_PORT, 32'hFFFFFFFF, 32'h00000080);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        $display("reset test done");
    endtask

    task automatic t_oc();
        wr(OFF_IMASK, 32'h4);
        oc_n <= 1'b0;
        wait_cyc(3);
        rchk(OFF_PORT, 32'h400, 32'h400);
        chk({31'h0, irq}, 32'h1);
        oc_n <= 1'b1;
        wait_cyc(3);
        rchk(OFF_PORT, 32'h400, 32'h0);
        wr(OFF_ISTAT, 32'h4);
        wait_cyc(2);
        chk({31'h0, irq}, 32'h0);
        // Masked event must stay silent on the pin
        wr(OFF_IMASK, 32'h0);
        oc_n <= 1'b0;
        wait_cyc(3);
        chk({31'h0, irq}, 32'h0);
        oc_n <= 1'b1;
        wr(OFF_ISTAT, 32'hF);
        $display("overcurrent test done");
    endtask

    task automatic t_line();
        plugged <= 1'b1;
        wait_cyc(4);
        rchk(OFF_PORT, 32'h30, 32'h0);
        frame_end();
        rchk(OFF_PORT, 32'h130, 32'h10);
        plugged <= 1'b0;
        wait_cyc(4);
        rchk(OFF_PORT, 32'h30, 32'h10);
        ls <= 1'b1;
        plugged <= 1'b1;
        wait_cyc(3);
        frame_end();
        rchk(OFF_PORT, 32'h130, 32'h120);
        wr(OFF_PORT, 32'h0);
        rchk(OFF_PORT, 32'h100, 32'h100);
        $display("line state test done");
    endtask

    task automatic t_enable();
        wr(OFF_PORT, 32'h4);
        rchk(OFF_PORT, 32'hC, 32'h4);
        port_fault <= 1'b1;
        frame_end();
        port_fault <= 1'b0;
        rchk(OFF_PORT, 32'hC, 32'h8);
        wr(OFF_PORT, 32'h0);
        rchk(OFF_PORT, 32'h8, 32'h8);
        wr(OFF_PORT, 32'h8);
        rchk(OFF_PORT, 32'h8, 32'h0);
        wr(OFF_PORT, 32'h4);
        wr(OFF_PORT, 32'h0);
        rchk(OFF_PORT, 32'hC, 32'h0);
        wr(OFF_PORT, 32'h4);
        plugged <= 1'b0;
        wait_cyc(3);
        rchk(OFF_PORT, 32'hC, 32'h8);
        wr(OFF_PORT, 32'h8);
        plugged <= 1'b1;
        wait_cyc(3);
        $display("enable change test done");
    endtask

    task automatic t_port_reset();
        wr(OFF_PORT, 32'h4);
        port_reset_req <= 1'b1;
        wait_cyc(3);
        chk({29'h0, line_oe_n, line_out}, 32'h0);
        rchk(OFF_PORT, 32'h204, 32'h200);
        port_reset_req <= 1'b0;
        wait_cyc(3);
        $display("port reset test done");
    endtask

    task automatic t_resume_sw();
        wr(OFF_PORT, 32'h40);
        wait_cyc(3);
        chk({29'h0, line_oe_n, line_out}, 32'h2);
        wr(OFF_PORT, 32'h0);
        rchk(OFF_PORT, 32'h40, 32'h40);
        wait_cyc(15);
        chk({29'h0, line_oe_n, line_out}, 32'h0);
        wait_cyc(50);
        rchk(OFF_PORT, 32'h40, 32'h0);
        $display("software resume test done");
    endtask

    task automatic t_resume_hw();
        wr(OFF_PORT, 32'h4);
        wr(OFF_PORT, 32'h1004);
        send_k <= 1'b1;
        wait_cyc(780);
        rchk(OFF_PORT, 32'h40, 32'h0);
        wait_cyc(40);
        rchk(OFF_PORT, 32'h40, 32'h40);
        send_k <= 1'b0;
        wait_cyc(3);
        chk({29'h0, line_oe_n, line_out}, 32'h2);
        // Leaving suspend with the bit kept must end the echo
        wr(OFF_PORT, 32'h44);
        wait_cyc(3);
        chk({31'h0, line_oe_n}, 32'h1);
        wr(OFF_PORT, 32'h4);
        wait_cyc(60);
        $display("detected resume test done");
    endtask

    // With the enable low an overcurrent must not reach the interrupt pin
    task automatic t_ce();
        wr(OFF_IMASK, 32'h4);
        ce <= 1'b0;
        oc_n <= 1'b0;
        wait_cyc(4);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'b1;
        wait_cyc(4);
        chk({31'h0, irq}, 32'h1);
        oc_n <= 1'b1;
        wr(OFF_ISTAT, 32'hF);
        wr(OFF_IMASK, 32'h0);
        $display("clock enable test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog at 20000 cycles, well past the about 1200 cycles the tests need
    initial
    begin
        #(40 * 20000);
        err_count++;
        summarize();
    end

    initial
    begin
        wait_cyc(20);
        presetn <= 1'b1;
        wait_cyc(2);
        t_reset();
        t_oc();
        t_line();
        t_enable();
        t_port_reset();
        t_resume_sw();
        t_resume_hw();
        t_ce();
        summarize();
    end
endmodule
